/* File: peripheral_transfer_map.svh */
// Purpose: Offsets, field positions and reset values of the transfer engine
// Assumes: Byte addresses within the peripheral's 4 KB register window
// Notes: Included by bare name wherever a constant is needed
`ifndef PERIPHERAL_TRANSFER_MAP_SVH
`define PERIPHERAL_TRANSFER_MAP_SVH

// APB address width seen by the block
`define XFER_AW 12
// Channel register offsets
`define OFS_RX_PTR 12'h100
`define OFS_RX_CNT 12'h104
`define OFS_TX_PTR 12'h108
`define OFS_TX_CNT 12'h10C
`define OFS_RX_NPTR 12'h110
`define OFS_RX_NCNT 12'h114
`define OFS_TX_NPTR 12'h118
`define OFS_TX_NCNT 12'h11C
`define OFS_CTRL 12'h120
`define OFS_STATE 12'h124
// Event status, enable and clear registers
`define OFS_EVT_STAT 12'h128
`define OFS_EVT_EN 12'h12C
`define OFS_EVT_CLR 12'h130
// Control and state bit positions
`define BIT_RX_EN 0
`define BIT_RX_DIS 1
`define BIT_TX_EN 8
`define BIT_TX_DIS 9
// Event bit positions
`define EVT_RX_DONE 0
`define EVT_RX_FULL 1
`define EVT_TX_DONE 2
`define EVT_TX_EMPTY 3
`define EVT_W 4
// Reset values
`define RST_PTR 32'h0000_0000
`define RST_CNT 16'h0000
`define RST_EVT 4'h0
// Pointer steps per transfer unit
`define INC_BYTE 3'h1
`define INC_HALF 3'h2
`define INC_WORD 3'h4

`endif

/* File: peripheral_transfer_pkg.sv */
// Purpose: Types shared by the transfer engine files
// Assumes: Nothing beyond the map header
// Notes: Unit codes match what the serial peripheral drives
package peripheral_transfer_pkg;

    // Size of one transfer unit
    typedef enum logic [1:0] {
        UNIT_BYTE = 2'h0,
        UNIT_HALF = 2'h1,
        UNIT_WORD = 2'h2
    } xfer_unit_e;

endpackage

/* File: xfer_channel.sv */
// Purpose: Current and next pointer/count pair of one transfer direction
// Assumes: One step per cycle at most; step ignored when count is zero
// Notes: A software write in the same cycle as a step wins for that register
`timescale 1ns/1ns
`include "peripheral_transfer_map.svh"

module xfer_channel #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_cur_ptr,
    input wire logic wr_cur_cnt,
    input wire logic wr_nxt_ptr,
    input wire logic wr_nxt_cnt,
    input wire logic [31:0] wdata,
    input wire logic step,
    input wire logic [2:0] step_inc,
    output logic [31:0] cur_ptr,
    output logic [CNT_W-1:0] cur_cnt,
    output logic [31:0] nxt_ptr,
    output logic [CNT_W-1:0] nxt_cnt,
    output logic end_evt,
    output logic buf_evt
);

    // Counts wider than the register field cannot be reached by software
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
        $error("CNT_W must be 1 to 16");
    end

    logic [31:0] cur_ptr_r, cur_ptr_nxt, nxt_ptr_r, nxt_ptr_nxt;
    logic [CNT_W-1:0] cur_cnt_r, cur_cnt_nxt, nxt_cnt_r, nxt_cnt_nxt;
    logic end_r, end_nxt, buf_r, buf_nxt;

    // Step, reload and software writes
    always_comb begin
        cur_ptr_nxt = cur_ptr_r;
        cur_cnt_nxt = cur_cnt_r;
        nxt_ptr_nxt = nxt_ptr_r;
        nxt_cnt_nxt = nxt_cnt_r;
        end_nxt = 1'b0;
        buf_nxt = 1'b0;
        // A zero count never moves data
        if (step && cur_cnt_r != '0) begin
            cur_ptr_nxt = cur_ptr_r + 32'(step_inc);
            cur_cnt_nxt = cur_cnt_r - CNT_W'(1);
            if (cur_cnt_r == CNT_W'(1)) begin
                end_nxt = 1'b1;
                if (nxt_cnt_r != '0) begin
                    // Chain into the next buffer
                    cur_ptr_nxt = nxt_ptr_r;
                    cur_cnt_nxt = nxt_cnt_r;
                    nxt_ptr_nxt = '0;
                    nxt_cnt_nxt = '0;
                end else begin
                    buf_nxt = 1'b1;
                end
            end
        end
        // Software wins so a reprogram is never lost
        if (wr_cur_ptr) begin
            cur_ptr_nxt = wdata;
        end
        if (wr_cur_cnt) begin
            cur_cnt_nxt = wdata[CNT_W-1:0];
        end
        if (wr_nxt_ptr) begin
            nxt_ptr_nxt = wdata;
        end
        if (wr_nxt_cnt) begin
            nxt_cnt_nxt = wdata[CNT_W-1:0];
        end
    end

    // Registers only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur_ptr_r <= `RST_PTR;
            cur_cnt_r <= '0;
            nxt_ptr_r <= `RST_PTR;
            nxt_cnt_r <= '0;
            end_r <= 1'b0;
            buf_r <= 1'b0;
        end else begin
            cur_ptr_r <= cur_ptr_nxt;
            cur_cnt_r <= cur_cnt_nxt;
            nxt_ptr_r <= nxt_ptr_nxt;
            nxt_cnt_r <= nxt_cnt_nxt;
            end_r <= end_nxt;
            buf_r <= buf_nxt;
        end
    end

    assign cur_ptr = cur_ptr_r;
    assign cur_cnt = cur_cnt_r;
    assign nxt_ptr = nxt_ptr_r;
    assign nxt_cnt = nxt_cnt_r;
    assign end_evt = end_r;
    assign buf_evt = buf_r;

endmodule

/* File: peripheral_transfer_engine.sv */
// Purpose: Register block and sequencing of one receive/transmit channel pair
// Assumes: Peripheral requests and unit codes are synchronous to mclk
// Notes: Memory master port lives outside; strobes here name the address
`timescale 1ns/1ns
`include "peripheral_transfer_map.svh"

// How it works
// - Thirteen registers at fixed offsets 0x100 to 0x130
// - Half duplex keeps receive and transmit pointers equal
// - Half duplex keeps receive and transmit counts equal
// - Zero receive count stops receive data movement
// - Nonzero count moves data only when enabled
// - Decrement count; reload from next, else stop
// - Pointer advances by one, two or four
// - Done at zero, buffer flag when both zero
// - Control enables unless disable set; state reports
module peripheral_transfer_engine #(
    parameter int CNT_W = 16,
    parameter bit HALF_DUPLEX = 1'b0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`XFER_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_ready,
    input wire logic [1:0] rx_unit,
    input wire logic tx_ready,
    input wire logic [1:0] tx_unit,
    output logic rx_xfer_strobe,
    output logic [31:0] rx_xfer_addr,
    output logic tx_xfer_strobe,
    output logic [31:0] tx_xfer_addr,
    output logic rx_segment_done,
    output logic rx_buffers_full,
    output logic tx_segment_done,
    output logic tx_buffers_empty,
    output logic irq
);

    // Larger counts would not fit the 16-bit register field
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
        $error("CNT_W must be 1 to 16");
    end

    // Pointer step for one unit; unused code treated as a word
    function automatic logic [2:0] unit_inc(input logic [1:0] u);
        case (peripheral_transfer_pkg::xfer_unit_e'(u))
            peripheral_transfer_pkg::UNIT_BYTE: unit_inc = `INC_BYTE;
            peripheral_transfer_pkg::UNIT_HALF: unit_inc = `INC_HALF;
            default: unit_inc = `INC_WORD;
        endcase
    endfunction

    // Bus phases
    logic setup_ph, wr_acc;
    // Decoded write strobes
    logic w_rpr, w_rcr, w_tpr, w_tcr, w_rnpr, w_rncr, w_tnpr, w_tncr;
    logic w_ctrl, w_en, w_clr;
    // Read mux output and hit
    logic [31:0] rd_val;
    logic hit;
    // Channel views
    logic [31:0] rx_cur_ptr, rx_nxt_ptr, tx_cur_ptr, tx_nxt_ptr;
    logic [CNT_W-1:0] rx_cur_cnt, rx_nxt_cnt, tx_cur_cnt, tx_nxt_cnt;
    logic rx_end_evt, rx_buf_evt, tx_end_evt, tx_buf_evt;
    // Channel strobes after half duplex aliasing
    logic c_rpr, c_rcr, c_rnpr, c_rncr, c_tpr, c_tcr, c_tnpr, c_tncr;
    // Transfer qualifiers
    logic rx_go, tx_go, rx_step, tx_step;
    logic [2:0] rx_inc, tx_inc;
    // Enable state
    logic rx_en_r, rx_en_nxt, tx_en_r, tx_en_nxt;
    // Peripheral flags
    logic rx_done_r, rx_done_nxt, rx_full_r, rx_full_nxt;
    logic tx_done_r, tx_done_nxt, tx_empty_r, tx_empty_nxt;
    logic rx_clr, tx_clr;
    // Event status and enable
    logic [`EVT_W-1:0] evt_stat_r, evt_stat_nxt, evt_en_r, evt_en_nxt, evt_set;
    // Strobe outputs
    logic rx_stb_r, rx_stb_nxt, tx_stb_r, tx_stb_nxt;
    logic [31:0] rx_addr_r, rx_addr_nxt, tx_addr_r, tx_addr_nxt;
    // Bus answer registers
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;

    assign setup_ph = psel && !penable;
    // Zero wait states, so every access phase completes
    assign wr_acc = psel && penable && pwrite;

    // Address decode and read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == `OFS_RX_PTR) begin
            rd_val = rx_cur_ptr;
        end else if (paddr == `OFS_RX_CNT) begin
            rd_val = 32'(rx_cur_cnt);
        end else if (paddr == `OFS_TX_PTR) begin
            rd_val = tx_cur_ptr;
        end else if (paddr == `OFS_TX_CNT) begin
            rd_val = 32'(tx_cur_cnt);
        end else if (paddr == `OFS_RX_NPTR) begin
            rd_val = rx_nxt_ptr;
        end else if (paddr == `OFS_RX_NCNT) begin
            rd_val = 32'(rx_nxt_cnt);
        end else if (paddr == `OFS_TX_NPTR) begin
            rd_val = tx_nxt_ptr;
        end else if (paddr == `OFS_TX_NCNT) begin
            rd_val = 32'(tx_nxt_cnt);
        end else if (paddr == `OFS_CTRL) begin
            // Write-only, reads as zero
            rd_val = 32'h0000_0000;
        end else if (paddr == `OFS_STATE) begin
            rd_val[`BIT_RX_EN] = rx_en_r;
            rd_val[`BIT_TX_EN] = tx_en_r;
        end else if (paddr == `OFS_EVT_STAT) begin
            rd_val = 32'(evt_stat_r);
        end else if (paddr == `OFS_EVT_EN) begin
            rd_val = 32'(evt_en_r);
        end else if (paddr == `OFS_EVT_CLR) begin
            rd_val = 32'h0000_0000;
        end else begin
            hit = 1'b0;
        end
    end

    // Write strobes; read-only offsets simply ignore writes
    assign w_rpr = wr_acc && paddr == `OFS_RX_PTR;
    assign w_rcr = wr_acc && paddr == `OFS_RX_CNT;
    assign w_tpr = wr_acc && paddr == `OFS_TX_PTR;
    assign w_tcr = wr_acc && paddr == `OFS_TX_CNT;
    assign w_rnpr = wr_acc && paddr == `OFS_RX_NPTR;
    assign w_rncr = wr_acc && paddr == `OFS_RX_NCNT;
    assign w_tnpr = wr_acc && paddr == `OFS_TX_NPTR;
    assign w_tncr = wr_acc && paddr == `OFS_TX_NCNT;
    assign w_ctrl = wr_acc && paddr == `OFS_CTRL;
    assign w_en = wr_acc && paddr == `OFS_EVT_EN;
    assign w_clr = wr_acc && paddr == `OFS_EVT_CLR;

    // Half duplex: either name writes both channels, so they stay equal
    assign c_rpr = w_rpr || (HALF_DUPLEX && w_tpr);
    assign c_tpr = w_tpr || (HALF_DUPLEX && w_rpr);
    assign c_rcr = w_rcr || (HALF_DUPLEX && w_tcr);
    assign c_tcr = w_tcr || (HALF_DUPLEX && w_rcr);
    assign c_rnpr = w_rnpr || (HALF_DUPLEX && w_tnpr);
    assign c_tnpr = w_tnpr || (HALF_DUPLEX && w_rnpr);
    assign c_rncr = w_rncr || (HALF_DUPLEX && w_tncr);
    assign c_tncr = w_tncr || (HALF_DUPLEX && w_rncr);

    // Requests honoured only when enabled with data left
    assign rx_go = rx_ready && rx_en_r && rx_cur_cnt != '0;
    assign tx_go = tx_ready && tx_en_r && tx_cur_cnt != '0;
    // Shared channel steps on either direction in half duplex
    assign rx_step = rx_go || (HALF_DUPLEX && tx_go);
    assign tx_step = tx_go || (HALF_DUPLEX && rx_go);
    assign rx_inc = (HALF_DUPLEX && tx_go) ? unit_inc(tx_unit) : unit_inc(rx_unit);
    assign tx_inc = (HALF_DUPLEX && rx_go) ? unit_inc(rx_unit) : unit_inc(tx_unit);

    // Receive channel registers
    xfer_channel #(
        .CNT_W(CNT_W)
    ) u_rx (
        .mclk(mclk),
        .nrst(nrst),
        .wr_cur_ptr(c_rpr),
        .wr_cur_cnt(c_rcr),
        .wr_nxt_ptr(c_rnpr),
        .wr_nxt_cnt(c_rncr),
        .wdata(pwdata),
        .step(rx_step),
        .step_inc(rx_inc),
        .cur_ptr(rx_cur_ptr),
        .cur_cnt(rx_cur_cnt),
        .nxt_ptr(rx_nxt_ptr),
        .nxt_cnt(rx_nxt_cnt),
        .end_evt(rx_end_evt),
        .buf_evt(rx_buf_evt)
    );

    // Transmit channel registers
    xfer_channel #(
        .CNT_W(CNT_W)
    ) u_tx (
        .mclk(mclk),
        .nrst(nrst),
        .wr_cur_ptr(c_tpr),
        .wr_cur_cnt(c_tcr),
        .wr_nxt_ptr(c_tnpr),
        .wr_nxt_cnt(c_tncr),
        .wdata(pwdata),
        .step(tx_step),
        .step_inc(tx_inc),
        .cur_ptr(tx_cur_ptr),
        .cur_cnt(tx_cur_cnt),
        .nxt_ptr(tx_nxt_ptr),
        .nxt_cnt(tx_nxt_cnt),
        .end_evt(tx_end_evt),
        .buf_evt(tx_buf_evt)
    );

    // Enable control; disable always beats enable
    always_comb begin
        rx_en_nxt = rx_en_r;
        tx_en_nxt = tx_en_r;
        if (w_ctrl) begin
            if (HALF_DUPLEX) begin
                // One direction at a time; receive enable takes priority
                if (pwdata[`BIT_RX_DIS] || pwdata[`BIT_TX_DIS]) begin
                    rx_en_nxt = 1'b0;
                    tx_en_nxt = 1'b0;
                end else if (pwdata[`BIT_RX_EN]) begin
                    rx_en_nxt = 1'b1;
                    tx_en_nxt = 1'b0;
                end else if (pwdata[`BIT_TX_EN]) begin
                    tx_en_nxt = 1'b1;
                    rx_en_nxt = 1'b0;
                end
            end else begin
                if (pwdata[`BIT_RX_DIS]) begin
                    rx_en_nxt = 1'b0;
                end else if (pwdata[`BIT_RX_EN]) begin
                    rx_en_nxt = 1'b1;
                end
                if (pwdata[`BIT_TX_DIS]) begin
                    tx_en_nxt = 1'b0;
                end else if (pwdata[`BIT_TX_EN]) begin
                    tx_en_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else begin
            rx_en_r <= rx_en_nxt;
            tx_en_r <= tx_en_nxt;
        end
    end

    // Peripheral flags: a nonzero count write clears, a new event wins
    assign rx_clr = (c_rcr || c_rncr) && pwdata[CNT_W-1:0] != '0;
    assign tx_clr = (c_tcr || c_tncr) && pwdata[CNT_W-1:0] != '0;

    always_comb begin
        rx_done_nxt = rx_end_evt || (rx_done_r && !rx_clr);
        rx_full_nxt = rx_buf_evt || (rx_full_r && !rx_clr);
        tx_done_nxt = tx_end_evt || (tx_done_r && !tx_clr);
        tx_empty_nxt = tx_buf_evt || (tx_empty_r && !tx_clr);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_done_r <= 1'b0;
            rx_full_r <= 1'b0;
            tx_done_r <= 1'b0;
            tx_empty_r <= 1'b0;
        end else begin
            rx_done_r <= rx_done_nxt;
            rx_full_r <= rx_full_nxt;
            tx_done_r <= tx_done_nxt;
            tx_empty_r <= tx_empty_nxt;
        end
    end

    // Sticky events; set beats a clear in the same cycle
    always_comb begin
        evt_set = '0;
        evt_set[`EVT_RX_DONE] = rx_end_evt;
        evt_set[`EVT_RX_FULL] = rx_buf_evt;
        evt_set[`EVT_TX_DONE] = tx_end_evt;
        evt_set[`EVT_TX_EMPTY] = tx_buf_evt;
        evt_stat_nxt = evt_stat_r;
        if (w_clr) begin
            evt_stat_nxt = evt_stat_r & ~pwdata[`EVT_W-1:0];
        end
        evt_stat_nxt = evt_stat_nxt | evt_set;
        evt_en_nxt = w_en ? pwdata[`EVT_W-1:0] : evt_en_r;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_stat_r <= `RST_EVT;
            evt_en_r <= `RST_EVT;
        end else begin
            evt_stat_r <= evt_stat_nxt;
            evt_en_r <= evt_en_nxt;
        end
    end

    // Transfer strobes carry the address used before the step
    always_comb begin
        rx_stb_nxt = rx_go;
        tx_stb_nxt = tx_go;
        rx_addr_nxt = rx_go ? rx_cur_ptr : rx_addr_r;
        tx_addr_nxt = tx_go ? tx_cur_ptr : tx_addr_r;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_stb_r <= 1'b0;
            tx_stb_r <= 1'b0;
            rx_addr_r <= `RST_PTR;
            tx_addr_r <= `RST_PTR;
        end else begin
            rx_stb_r <= rx_stb_nxt;
            tx_stb_r <= tx_stb_nxt;
            rx_addr_r <= rx_addr_nxt;
            tx_addr_r <= tx_addr_nxt;
        end
    end

    // Read data captured in setup; a step in that cycle shows next read
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_ph) begin
            prdata_nxt = pwrite ? 32'h0000_0000 : rd_val;
            pslverr_nxt = !hit;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r && psel && penable;
    assign rx_xfer_strobe = rx_stb_r;
    assign rx_xfer_addr = rx_addr_r;
    assign tx_xfer_strobe = tx_stb_r;
    assign tx_xfer_addr = tx_addr_r;
    assign rx_segment_done = rx_done_r;
    assign rx_buffers_full = rx_full_r;
    assign tx_segment_done = tx_done_r;
    assign tx_buffers_empty = tx_empty_r;
    assign irq = |(evt_stat_r & evt_en_r);

    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic rx_quiet;
    assign rx_quiet = !c_rpr && !c_rcr && !c_rnpr && !c_rncr;

    map_rx_ptr_a: assert property (
        setup_ph && !pwrite && paddr == `OFS_RX_PTR |=> prdata == $past(rx_cur_ptr))
        else $error("receive pointer read mismatch");
    half_ptr_a: assert property (HALF_DUPLEX |-> rx_cur_ptr == tx_cur_ptr)
        else $error("half duplex pointers differ");
    half_cnt_a: assert property (HALF_DUPLEX |-> rx_cur_cnt == tx_cur_cnt)
        else $error("half duplex counts differ");
    zero_stop_a: assert property (rx_cur_cnt == '0 |=> !rx_xfer_strobe)
        else $error("receive moved data at zero count");
    gate_en_a: assert property (rx_xfer_strobe |-> $past(rx_en_r) && $past(rx_ready))
        else $error("receive strobe without enable");
    cnt_dec_a: assert property (
        rx_step && rx_quiet && rx_cur_cnt > CNT_W'(1)
        |=> rx_cur_cnt == $past(rx_cur_cnt) - CNT_W'(1))
        else $error("receive count not decremented");
    chain_load_a: assert property (
        rx_step && rx_quiet && rx_cur_cnt == CNT_W'(1) && rx_nxt_cnt != '0
        |=> rx_cur_cnt == $past(rx_nxt_cnt) && rx_nxt_cnt == '0)
        else $error("next buffer not chained");
    ptr_step_a: assert property (
        rx_step && rx_quiet && rx_cur_cnt > CNT_W'(1)
        |=> rx_cur_ptr == $past(rx_cur_ptr) + 32'($past(rx_inc)))
        else $error("receive pointer step wrong");
    full_flag_a: assert property (
        rx_step && rx_quiet && rx_cur_cnt == CNT_W'(1) && rx_nxt_cnt == '0
        |=> ##1 rx_segment_done && rx_buffers_full)
        else $error("receive end flags missing");
    ctl_dis_a: assert property (
        w_ctrl && pwdata[`BIT_RX_DIS] |=> !rx_en_r)
        else $error("receive disable ignored");
    cnt_upper_a: assert property (
        psel && penable && !pwrite && paddr == `OFS_RX_CNT |-> prdata[31:16] == 16'h0000)
        else $error("count upper bits not zero");

    chain_c: cover property (rx_step && rx_cur_cnt == CNT_W'(1) && rx_nxt_cnt != '0);
    tx_empty_c: cover property ($rose(tx_buffers_empty));
    irq_c: cover property ($rose(irq));
    both_en_c: cover property (rx_en_r && tx_en_r);

endmodule

/* File: host_peripheral_prefix_model.sv */
// Purpose: Serial peripheral stand-in that raises receive and transmit requests
// Assumes: Called just after a rising edge of mclk
// Notes: Unit code is inverted when idle so a stale value is never trusted
`timescale 1ns/1ns
module host_peripheral_prefix_model (
    input wire logic mclk,
    output logic rx_ready,
    output logic [1:0] rx_unit,
    output logic tx_ready,
    output logic [1:0] tx_unit
);
    initial begin
        rx_ready = 1'b0;
        tx_ready = 1'b0;
        rx_unit = 2'h0;
        tx_unit = 2'h0;
    end
    // One unit per request cycle; slow mode idles a cycle between units
    task automatic send(input bit tx, input int n, input logic [1:0] u, input bit slow);
        repeat (n) begin
            rx_ready <= !tx;
            tx_ready <= tx;
            rx_unit <= tx ? ~u : u;
            tx_unit <= tx ? u : ~u;
            @(posedge mclk);
            if (slow) begin
                rx_ready <= 1'b0;
                tx_ready <= 1'b0;
                @(posedge mclk);
            end
        end
        rx_ready <= 1'b0;
        tx_ready <= 1'b0;
        rx_unit <= ~u;
        tx_unit <= ~u;
    endtask
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the transfer engine register block
// Assumes: Full duplex build plus a half duplex copy on the same bus, zero wait states
// Notes: Strobe addresses are logged on the falling edge, once settled
`timescale 1ns/1ns
`include "peripheral_transfer_map.svh"
module testbench;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rx_xfer_addr, tx_xfer_addr, hd_prdata;
    logic rx_ready, tx_ready, rx_xfer_strobe, tx_xfer_strobe;
    logic [1:0] rx_unit, tx_unit;
    logic rx_segment_done, rx_buffers_full, tx_segment_done, tx_buffers_empty;
    logic [31:0] rx_q[$], tx_q[$];
    int fails = 0, n_compared = 0;
    peripheral_transfer_engine peripheral_transfer_engine_inst (.mclk, .nrst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_ready,
        .rx_unit, .tx_ready, .tx_unit, .rx_xfer_strobe, .rx_xfer_addr, .tx_xfer_strobe,
        .tx_xfer_addr, .rx_segment_done, .rx_buffers_full, .tx_segment_done,
        .tx_buffers_empty, .irq);
    // Half duplex copy sees every bus cycle and request; only its read data is judged
    peripheral_transfer_engine #(.HALF_DUPLEX(1'b1)) peripheral_transfer_engine_hd_inst (
        .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(hd_prdata),
        .pready(), .pslverr(), .rx_ready, .rx_unit, .tx_ready, .tx_unit,
        .rx_xfer_strobe(), .rx_xfer_addr(), .tx_xfer_strobe(), .tx_xfer_addr(),
        .rx_segment_done(), .rx_buffers_full(), .tx_segment_done(),
        .tx_buffers_empty(), .irq());
    host_peripheral_prefix_model host_peripheral_prefix_model_inst (.mclk, .rx_ready, .rx_unit, .tx_ready, .tx_unit);
    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Memory-side address log
    always @(negedge mclk) begin
        if (rx_xfer_strobe === 1'b1) rx_q.push_back(rx_xfer_addr);
        if (tx_xfer_strobe === 1'b1) tx_q.push_back(tx_xfer_addr);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; an idle cycle follows so strobes never toggle twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_map;
        for (int i = 0; i < 10; i++) rdchk(12'h100 + 12'(4 * i), 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `OFS_RX_CNT, 32'hFFFF_ABCD);
        rdchk(`OFS_RX_CNT, 32'h0000_ABCD);
        apb(1'b1, `OFS_RX_CNT, 32'h0);
        $display("done map");
    endtask
    task automatic t_rx_chain;
        rx_q.delete();
        apb(1'b1, `OFS_RX_PTR, 32'h0000_1000);
        apb(1'b1, `OFS_RX_CNT, 32'h2);
        apb(1'b1, `OFS_RX_NPTR, 32'h0000_2000);
        apb(1'b1, `OFS_RX_NCNT, 32'h1);
        host_peripheral_prefix_model_inst.send(1'b0, 1, 2'h1, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h1);
        rdchk(`OFS_STATE, 32'h1);
        host_peripheral_prefix_model_inst.send(1'b0, 4, 2'h1, 1'b0);
        repeat (3) @(posedge mclk);
        chk(rx_q.size(), 3);
        chk(rx_q[0], 32'h0000_1000);
        chk(rx_q[1], 32'h0000_1002);
        chk(rx_q[2], 32'h0000_2000);
        rdchk(`OFS_RX_PTR, 32'h0000_2002);
        rdchk(`OFS_RX_NPTR, 32'h0);
        chk({rx_segment_done, rx_buffers_full}, 32'h3);
        apb(1'b1, `OFS_RX_NCNT, 32'h1);
        chk({rx_segment_done, rx_buffers_full}, 32'h0);
        $display("done rx_chain");
    endtask
    task automatic t_tx_irq;
        tx_q.delete();
        apb(1'b1, `OFS_TX_PTR, 32'h0000_3000);
        apb(1'b1, `OFS_TX_CNT, 32'h2);
        apb(1'b1, `OFS_EVT_EN, 32'h4);
        apb(1'b1, `OFS_CTRL, 32'h100);
        host_peripheral_prefix_model_inst.send(1'b1, 3, 2'h2, 1'b1);
        repeat (3) @(posedge mclk);
        chk(tx_q.size(), 2);
        chk(tx_q[1], 32'h0000_3004);
        chk({tx_segment_done, tx_buffers_empty, irq}, 32'h7);
        rdchk(`OFS_EVT_STAT, 32'hF);
        apb(1'b1, `OFS_EVT_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `OFS_EVT_EN, 32'h4);
        apb(1'b1, `OFS_EVT_CLR, 32'hF);
        chk({31'h0, irq}, 32'h0);
        rdchk(`OFS_EVT_STAT, 32'h0);
        $display("done tx_irq");
    endtask
    task automatic t_ctrl;
        rx_q.delete();
        apb(1'b1, `OFS_CTRL, 32'h303);
        rdchk(`OFS_STATE, 32'h0);
        apb(1'b1, `OFS_RX_PTR, 32'h0000_0010);
        apb(1'b1, `OFS_RX_CNT, 32'h1);
        // Leftover next count would chain and overwrite the pointer
        apb(1'b1, `OFS_RX_NCNT, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h1);
        host_peripheral_prefix_model_inst.send(1'b0, 1, 2'h0, 1'b0);
        repeat (2) @(posedge mclk);
        chk(rx_q[0], 32'h0000_0010);
        rdchk(`OFS_RX_PTR, 32'h0000_0011);
        $display("done ctrl");
    endtask
    // Half duplex copy: one shared pointer and count, stepped here by a transmit request
    task automatic t_half;
        apb(1'b1, `OFS_TX_PTR, 32'h0000_4000);
        apb(1'b1, `OFS_TX_CNT, 32'h5);
        apb(1'b0, `OFS_RX_PTR, 32'h0);
        chk(hd_prdata, 32'h0000_4000);
        apb(1'b0, `OFS_RX_CNT, 32'h0);
        chk(hd_prdata, 32'h5);
        apb(1'b1, `OFS_CTRL, 32'h100);
        host_peripheral_prefix_model_inst.send(1'b1, 1, 2'h0, 1'b0);
        repeat (2) @(posedge mclk);
        apb(1'b0, `OFS_RX_CNT, 32'h0);
        chk(hd_prdata, 32'h4);
        apb(1'b0, `OFS_RX_PTR, 32'h0);
        chk(hd_prdata, 32'h0000_4001);
        $display("done half");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog well beyond the roughly 180 cycles the tests need
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_map();
        t_rx_chain();
        t_tx_irq();
        t_ctrl();
        t_half();
        end_sim();
    end
endmodule
